// ==== sim/ubdsc_ctrl_tb.sv ====
/*
 * Self-checking bench for the serial channel support block.
 * Assumes the register map and timing given in the package.
 */
`timescale 1ns/10ps
module ubdsc_ctrl_tb;
	logic sys_clk = 0, reset_n = 0, start_frame = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, prescale_select_pin = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'h1, modem_in = 4'h0;
	logic tx_serial_data = 1, tx_shift_empty = 1, rx_error_in_fifo = 0;
	logic other_int_pending = 0, rx_fifo_read = 0, tx_fifo_write = 0;
	logic [6:0] rx_fifo_count = 0, tx_fifo_count = 0;
	logic [6:0] rx_trigger_level = 4, tx_trigger_spaces = 8;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, serial_in, serial_out, baud_tick16, bit_tick;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic uart_clock_run, rx_timeout, tx_dma_request_n, rx_dma_request_n;
	logic sleeping;
	logic [7:0] line_control, fifo_control;
	int num_errors = 0;
	int check_count = 0;
	int n;

	ubdsc_ctrl dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_in, .modem_in,
		.prescale_select_pin, .tx_serial_data, .serial_out, .rx_fifo_count,
		.tx_fifo_count, .rx_trigger_level, .tx_trigger_spaces,
		.tx_shift_empty, .rx_error_in_fifo, .other_int_pending,
		.rx_fifo_read, .tx_fifo_write, .baud_tick16, .bit_tick,
		.uart_clock_run, .rx_timeout, .tx_dma_request_n, .rx_dma_request_n,
		.sleeping, .line_control, .fifo_control);
	ubdsc_remote remote (.sys_clk, .reset_n, .start_frame,
		.line(serial_in));

	task final_report;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task hang(input string nm);
		chk(nm, 1, 0);
		final_report();
	endtask : hang

	task axi_write(input logic [7:0] a, input logic [7:0] d,
		input logic [1:0] er = ubdsc_pkg::AXI_OKAY);
		int k;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (k = 0; k < 50; k++) begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'h1)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1)
				s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1)
				break;
		end
		if (k == 50)
			hang("bvalid");
		s_axi_bready <= 1'h0;
		chk("bresp", er, s_axi_bresp);
	endtask : axi_write

	task axi_read(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = ubdsc_pkg::AXI_OKAY);
		int k;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (k = 0; k < 50; k++) begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'h1)
				s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1)
				break;
		end
		if (k == 50)
			hang("rvalid");
		s_axi_rready <= 1'h0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", er, s_axi_rresp);
	endtask : axi_read

	// Counts edges until the selected output is seen high; any other sel waits for sleeping low
	task wait_for(input int sel, input int lim, output int k);
		logic s;
		for (k = 1; k <= lim; k++) begin
			@(posedge sys_clk);
			case (sel)
				0: s = sleeping;
				1: s = rx_timeout;
				2: s = baud_tick16;
				3: s = bit_tick;
				default: s = (sleeping === 1'h0);
			endcase
			if (s === 1'h1)
				break;
		end
		if (k > lim)
			hang("wait");
	endtask : wait_for

	task count_ticks(output int k);
		k = 0;
		repeat (100) begin
			@(posedge sys_clk);
			k += (baud_tick16 === 1'h1);
		end
	endtask : count_ticks

	task dma(input int tc, input int rc, input logic er, input logic et,
		input logic ex);
		tx_fifo_count <= 7'(tc);
		rx_fifo_count <= 7'(rc);
		rx_error_in_fifo <= er;
		repeat (3) @(posedge sys_clk);
		chk("tx_dma", et, tx_dma_request_n);
		chk("rx_dma", ex, rx_dma_request_n);
	endtask : dma

	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		chk("line_control", 8'h1d, line_control);
		chk("serial_out", 1, serial_out);
		reset_n <= 1'h1;
		axi_write(8'h20, 8'h01, ubdsc_pkg::AXI_SLVERR);
		axi_read(8'h20, 0, ubdsc_pkg::AXI_SLVERR);
		axi_write(ubdsc_pkg::LINE_CTRL_OFS, 8'h5d);
		repeat (2) @(posedge sys_clk);
		chk("break", 0, serial_out);
		axi_write(ubdsc_pkg::LINE_CTRL_OFS, 8'h1d);
		repeat (2) @(posedge sys_clk);
		chk("serial_out", 1, serial_out);
		count_ticks(n);
		chk("no_ticks", 0, n);
		axi_write(ubdsc_pkg::MODEM_CTRL_OFS, 8'h80);
		axi_read(ubdsc_pkg::MODEM_CTRL_OFS, 0);
		axi_write(ubdsc_pkg::INT_ENABLE_OFS, 8'hf1);
		axi_read(ubdsc_pkg::INT_ENABLE_OFS, 8'h01);
		axi_write(ubdsc_pkg::ENH_FEATURE_OFS, 8'h10);
		axi_write(ubdsc_pkg::MODEM_CTRL_OFS, 8'h80);
		axi_read(ubdsc_pkg::MODEM_CTRL_OFS, 8'h80);
		axi_read(ubdsc_pkg::STATUS_OFS, 8'h03);
		axi_write(ubdsc_pkg::DIV_LOW_OFS, 8'h02);
		wait_for(2, 50, n);
		wait_for(2, 50, n);
		chk("tick_gap", 8, n);
		wait_for(3, 200, n);
		wait_for(3, 200, n);
		chk("bit_gap", 128, n);
		axi_write(ubdsc_pkg::MODEM_CTRL_OFS, 8'h00);
		axi_write(ubdsc_pkg::DIV_HIGH_OFS, 8'h01);
		axi_write(ubdsc_pkg::DIV_LOW_OFS, 8'h00);
		wait_for(2, 300, n);
		wait_for(2, 300, n);
		chk("tick_gap", 256, n);
		axi_write(ubdsc_pkg::DIV_LOW_OFS, 8'h01);
		axi_write(ubdsc_pkg::DIV_HIGH_OFS, 8'h00);
		dma(1, 0, 0, 1, 1);
		dma(0, 1, 0, 0, 0);
		dma(0, 0, 0, 0, 1);
		axi_write(ubdsc_pkg::FIFO_CTRL_OFS, 8'h08);
		dma(1, 0, 0, 1, 1);
		axi_write(ubdsc_pkg::FIFO_CTRL_OFS, 8'h09);
		chk("fifo_control", 8'h09, fifo_control);
		dma(1, 0, 0, 0, 1);
		dma(64, 2, 0, 1, 1);
		dma(60, 4, 0, 1, 0);
		dma(50, 4, 1, 0, 1);
		dma(0, 0, 0, 0, 1);
		rx_trigger_level <= 7'h0a;
		dma(0, 1, 0, 0, 1);
		repeat (480) @(posedge sys_clk);
		chk("rx_timeout", 0, rx_timeout);
		wait_for(1, 150, n);
		chk("timeout_at", 1, n >= 70 && n <= 100);
		repeat (2) @(posedge sys_clk);
		chk("rx_dma", 0, rx_dma_request_n);
		rx_fifo_read <= 1'h1;
		@(posedge sys_clk);
		rx_fifo_read <= 1'h0;
		repeat (2) @(posedge sys_clk);
		chk("rx_timeout", 0, rx_timeout);
		dma(0, 0, 0, 0, 1);
		other_int_pending <= 1'h1;
		axi_write(ubdsc_pkg::INT_ENABLE_OFS, 8'h10);
		repeat (20) @(posedge sys_clk);
		chk("sleeping", 0, sleeping);
		other_int_pending <= 1'h0;
		wait_for(0, 50, n);
		chk("clock_run", 0, uart_clock_run);
		count_ticks(n);
		chk("sleep_ticks", 0, n);
		modem_in <= 4'h1;
		wait_for(4, 10, n);
		wait_for(0, 100, n);
		start_frame <= 1'h1;
		@(posedge sys_clk);
		start_frame <= 1'h0;
		wait_for(4, 10, n);
		wait_for(0, 100, n);
		tx_fifo_write <= 1'h1;
		@(posedge sys_clk);
		tx_fifo_write <= 1'h0;
		wait_for(4, 10, n);
		wait_for(0, 100, n);
		axi_write(ubdsc_pkg::ENH_FEATURE_OFS, 8'h00);
		wait_for(4, 10, n);
		prescale_select_pin <= 1'h1;
		reset_n <= 1'h0;
		repeat (3) @(posedge sys_clk);
		chk("serial_out", 1, serial_out);
		reset_n <= 1'h1;
		repeat (4) @(posedge sys_clk);
		axi_read(ubdsc_pkg::MODEM_CTRL_OFS, 8'h80);
		axi_read(ubdsc_pkg::STATUS_OFS, 8'h03);
		final_report();
	end
endmodule : ubdsc_ctrl_tb

// ==== sim/ubdsc_remote.sv ====
/*
 * Remote serial transceiver model that drives the receive line.
 * Assumes the bench clock and a one-cycle start_frame pulse.
 */
`timescale 1ns/10ps
module ubdsc_remote (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic start_frame,
	output logic line
);
	logic [4:0] bit_cnt_q;
	// A start bit holds the line low for one 16-clock bit time
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			bit_cnt_q <= 5'h00;
		else if (start_frame)
			bit_cnt_q <= 5'h10;
		else if (bit_cnt_q != 5'h00)
			bit_cnt_q <= bit_cnt_q - 5'h01;
	end
	// Idle line rests high between frames
	assign line = (bit_cnt_q == 5'h00);
endmodule : ubdsc_remote

// ==== src/ubdsc_baud_gen.sv ====
/*
 * Prescaler and 16-bit baud divisor giving a 16x tick and a bit tick.
 * Assumes the divisor is steady while running; zero stops all ticks.
 */
`timescale 1ns/10ps
module ubdsc_baud_gen (
	input wire logic sys_clk,
	input wire logic reset_n,
	ubdsc_baud_if.gen baud
);

	logic [1:0] pre_cnt_q;
	logic [15:0] div_cnt_q;
	logic [3:0] sub_cnt_q;
	logic pre_tick;
	logic div_hit;

	assign pre_tick = !baud.prescale4 || (pre_cnt_q == ubdsc_pkg::PRESCALE4_M1);
	// Compare with >= so a divisor lowered mid-count cannot stall for 2^16
	assign div_hit = pre_tick && (div_cnt_q >= baud.divisor - 16'h0001);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pre_cnt_q <= 2'h0;
		end else if (!baud.run) begin
			pre_cnt_q <= 2'h0;
		end else begin
			pre_cnt_q <= pre_tick ? 2'h0 : pre_cnt_q + 2'h1;
		end
	end

	// Divisor counter; a zero divisor never produces a tick
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt_q <= 16'h0000;
		end else if (!baud.run || baud.divisor == 16'h0000) begin
			div_cnt_q <= 16'h0000;
		end else if (pre_tick) begin
			div_cnt_q <= div_hit ? 16'h0000 : div_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			baud.tick16 <= 1'b0;
			baud.bit_tick <= 1'b0;
			sub_cnt_q <= 4'h0;
		end else begin
			baud.tick16 <= baud.run && baud.divisor != 16'h0000 && div_hit;
			baud.bit_tick <= baud.run && baud.divisor != 16'h0000 && div_hit
				&& sub_cnt_q == ubdsc_pkg::TICKS_PER_BIT_M1;
			if (!baud.run) begin
				sub_cnt_q <= 4'h0;
			end else if (baud.divisor != 16'h0000 && div_hit) begin
				sub_cnt_q <= sub_cnt_q + 4'h1;
			end
		end
	end

endmodule : ubdsc_baud_gen

// ==== src/ubdsc_baud_if.sv ====
/*
 * Carrier between the control logic and the baud generator.
 * Assumes both ends run on the same reference clock.
 */
`timescale 1ns/10ps
interface ubdsc_baud_if;
	logic [15:0] divisor;
	logic prescale4;
	logic run;
	logic tick16;
	logic bit_tick;

	modport gen (input divisor, input prescale4, input run,
		output tick16, output bit_tick);
	modport ctl (output divisor, output prescale4, output run,
		input tick16, input bit_tick);
endinterface : ubdsc_baud_if

// ==== src/ubdsc_ctrl.sv ====
/*
 * Serial channel support: receive timeout, break, baud control, DMA
 * request signalling, sleep and the enhanced-function write lock, with
 * an AXI4-Lite register slave. Assumes FIFO and shifter logic on the same
 * clock supply counts and pulses; line and strap pins are asynchronous.
 */
`timescale 1ns/10ps
module ubdsc_ctrl #(
	parameter int FIFO_DEPTH = 64,
	parameter int CNT_W = 7,
	parameter int MODEM_W = 4
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_in,
	input wire logic [MODEM_W-1:0] modem_in,
	input wire logic prescale_select_pin,
	input wire logic tx_serial_data,
	output logic serial_out,
	input wire logic [CNT_W-1:0] rx_fifo_count,
	input wire logic [CNT_W-1:0] tx_fifo_count,
	input wire logic [CNT_W-1:0] rx_trigger_level,
	input wire logic [CNT_W-1:0] tx_trigger_spaces,
	input wire logic tx_shift_empty,
	input wire logic rx_error_in_fifo,
	input wire logic other_int_pending,
	input wire logic rx_fifo_read,
	input wire logic tx_fifo_write,
	output logic baud_tick16,
	output logic bit_tick,
	output logic uart_clock_run,
	output logic rx_timeout,
	output logic tx_dma_request_n,
	output logic rx_dma_request_n,
	output logic sleeping,
	output logic [7:0] line_control,
	output logic [7:0] fifo_control
);

	localparam logic [CNT_W-1:0] DEPTH = CNT_W'(FIFO_DEPTH);
	localparam logic [CNT_W-1:0] CNT_ZERO = '0;

	ubdsc_baud_if baud ();

	logic [7:0] line_control_reg_q;
	logic [7:0] interrupt_enable_reg_q;
	logic [7:0] fifo_control_reg_q;
	logic [7:0] modem_control_reg_q;
	logic [7:0] enhanced_feature_reg_q;
	logic [7:0] divisor_low_byte_q;
	logic [7:0] divisor_high_byte_q;

	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [7:0] w_data_q;
	logic w_lane0_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic do_write;
	logic [7:0] wr_sel;
	logic enhanced_on;

	logic [1:0] rx_sync_q;
	logic rx_prev_q;
	logic [MODEM_W-1:0] modem_sync1_q;
	logic [MODEM_W-1:0] modem_sync2_q;
	logic [MODEM_W-1:0] modem_prev_q;
	logic [1:0] strap_sync_q;
	logic [1:0] strap_wait_q;
	logic strap_done_q;

	logic [5:0] idle_bits_q;
	logic [5:0] timeout_limit;
	logic timeout_hit;
	logic rx_timeout_q;
	logic serial_out_q;
	logic tx_req_n_q;
	logic rx_req_n_q;
	logic block_mode;
	logic [CNT_W-1:0] tx_free;
	logic sleep_enable;
	logic sleep_ready;
	logic wake_event;
	ubdsc_pkg::ubdsc_sleep_type sleep_q;

	// One-hot register select; zero means unmapped
	function automatic logic [7:0] reg_select(input logic [7:0] addr);
		reg_select = {addr == ubdsc_pkg::STATUS_OFS,
			addr == ubdsc_pkg::DIV_HIGH_OFS,
			addr == ubdsc_pkg::DIV_LOW_OFS,
			addr == ubdsc_pkg::ENH_FEATURE_OFS,
			addr == ubdsc_pkg::MODEM_CTRL_OFS,
			addr == ubdsc_pkg::FIFO_CTRL_OFS,
			addr == ubdsc_pkg::INT_ENABLE_OFS,
			addr == ubdsc_pkg::LINE_CTRL_OFS};
	endfunction : reg_select

	// Locked bits keep their old value unless enhanced functions are on
	function automatic logic [7:0] locked_write(input logic [7:0] old_val,
		input logic [7:0] new_val, input logic [7:0] mask, input logic open);
		logic [7:0] keep;
		keep = open ? 8'h00 : mask;
		locked_write = (new_val & ~keep) | (old_val & keep);
	endfunction : locked_write

	// AXI4-Lite write channel
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign wr_sel = reg_select(aw_addr_q) & {8{do_write && w_lane0_q}};
	assign enhanced_on = enhanced_feature_reg_q[ubdsc_pkg::EFR_ENHANCED_BIT];

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 8'h00;
			w_lane0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= ubdsc_pkg::AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata[7:0];
				w_lane0_q <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (reg_select(aw_addr_q) == 8'h00) ?
					ubdsc_pkg::AXI_SLVERR : ubdsc_pkg::AXI_OKAY;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Control registers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			line_control_reg_q <= ubdsc_pkg::LINE_CTRL_RESET;
			interrupt_enable_reg_q <= ubdsc_pkg::INT_ENABLE_RESET;
			fifo_control_reg_q <= ubdsc_pkg::FIFO_CTRL_RESET;
			enhanced_feature_reg_q <= ubdsc_pkg::ENH_FEATURE_RESET;
			divisor_low_byte_q <= ubdsc_pkg::DIVISOR_RESET;
			divisor_high_byte_q <= ubdsc_pkg::DIVISOR_RESET;
		end else begin
			if (wr_sel[0]) line_control_reg_q <= w_data_q;
			if (wr_sel[1]) begin
				interrupt_enable_reg_q <= locked_write(interrupt_enable_reg_q,
					w_data_q, ubdsc_pkg::IER_LOCK_MASK, enhanced_on);
			end
			if (wr_sel[2]) begin
				fifo_control_reg_q <= locked_write(fifo_control_reg_q,
					w_data_q, ubdsc_pkg::FCR_LOCK_MASK, enhanced_on);
			end
			if (wr_sel[4]) enhanced_feature_reg_q <= w_data_q;
			if (wr_sel[5]) divisor_low_byte_q <= w_data_q;
			if (wr_sel[6]) divisor_high_byte_q <= w_data_q;
		end
	end

	// Modem control; prescale strap caught once the pin is synchronised
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			modem_control_reg_q <= ubdsc_pkg::MODEM_CTRL_RESET;
			strap_wait_q <= 2'h0;
			strap_done_q <= 1'b0;
		end else begin
			if (!strap_done_q && strap_wait_q != ubdsc_pkg::STRAP_SYNC_CYCLES) begin
				strap_wait_q <= strap_wait_q + 2'h1;
			end
			if (wr_sel[3]) begin
				modem_control_reg_q <= locked_write(modem_control_reg_q,
					w_data_q, ubdsc_pkg::MCR_LOCK_MASK, enhanced_on);
			end else if (!strap_done_q
				&& strap_wait_q == ubdsc_pkg::STRAP_SYNC_CYCLES) begin
				modem_control_reg_q[ubdsc_pkg::MCR_PRESCALE_BIT] <=
					strap_sync_q[1];
			end
			if (strap_wait_q == ubdsc_pkg::STRAP_SYNC_CYCLES) strap_done_q <= 1'b1;
		end
	end

	// AXI4-Lite read channel
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= ubdsc_pkg::AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= ubdsc_pkg::AXI_OKAY;
			unique case (reg_select(s_axi_araddr))
				8'h01: rdata_q <= {24'h000000, line_control_reg_q};
				8'h02: rdata_q <= {24'h000000, interrupt_enable_reg_q};
				8'h04: rdata_q <= {24'h000000, fifo_control_reg_q};
				8'h08: rdata_q <= {24'h000000, modem_control_reg_q};
				8'h10: rdata_q <= {24'h000000, enhanced_feature_reg_q};
				8'h20: rdata_q <= {24'h000000, divisor_low_byte_q};
				8'h40: rdata_q <= {24'h000000, divisor_high_byte_q};
				8'h80: rdata_q <= {27'h0000000, sleeping, rx_timeout_q,
					!rx_req_n_q, !tx_req_n_q, baud.prescale4};
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= ubdsc_pkg::AXI_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// Pin synchronisers
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_sync_q <= 2'b11;
			rx_prev_q <= 1'b1;
			modem_sync1_q <= '0;
			modem_sync2_q <= '0;
			modem_prev_q <= '0;
			strap_sync_q <= 2'b00;
		end else begin
			rx_sync_q <= {rx_sync_q[0], serial_in};
			rx_prev_q <= rx_sync_q[1];
			modem_sync1_q <= modem_in;
			modem_sync2_q <= modem_sync1_q;
			modem_prev_q <= modem_sync2_q;
			strap_sync_q <= {strap_sync_q[0], prescale_select_pin};
		end
	end

	// Baud generator shared by transmitter and receiver
	assign baud.divisor = {divisor_high_byte_q, divisor_low_byte_q};
	assign baud.prescale4 = modem_control_reg_q[ubdsc_pkg::MCR_PRESCALE_BIT];
	assign baud.run = (sleep_q == ubdsc_pkg::SLEEP_AWAKE);
	assign baud_tick16 = baud.tick16;
	assign bit_tick = baud.bit_tick;
	assign uart_clock_run = baud.run;

	ubdsc_baud_gen u_baud_gen (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.baud(baud)
	);

	// Break forces the line low
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_out_q <= 1'b1;
		end else begin
			serial_out_q <= line_control_reg_q[ubdsc_pkg::LCR_BREAK_BIT] ?
				1'b0 : tx_serial_data;
		end
	end
	assign serial_out = serial_out_q;
	assign line_control = line_control_reg_q;
	assign fifo_control = fifo_control_reg_q;

	// Receive timeout: idle bit times counted while data is waiting
	assign timeout_limit = ubdsc_pkg::TIMEOUT_MULT * (ubdsc_pkg::WLEN_MIN_BITS
		+ {4'h0, line_control_reg_q[ubdsc_pkg::LCR_WLEN_LSB +: 2]})
		+ ubdsc_pkg::TIMEOUT_EXTRA_BITS;
	// Event on the bit time that reaches the limit, so a read can clear it
	assign timeout_hit = baud.bit_tick && rx_sync_q[1]
		&& idle_bits_q == timeout_limit - 6'h01
		&& rx_fifo_count != CNT_ZERO;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_bits_q <= 6'h00;
		end else if (!rx_sync_q[1] || rx_fifo_count == CNT_ZERO
			|| rx_fifo_read) begin
			idle_bits_q <= 6'h00;
		end else if (baud.bit_tick && idle_bits_q != timeout_limit) begin
			idle_bits_q <= idle_bits_q + 6'h01;
		end
	end

	// Set wins over the clear from a read or an empty FIFO
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_timeout_q <= 1'b0;
		end else if (timeout_hit) begin
			rx_timeout_q <= 1'b1;
		end else if (rx_fifo_read || rx_fifo_count == CNT_ZERO) begin
			rx_timeout_q <= 1'b0;
		end
	end
	assign rx_timeout = rx_timeout_q;

	// DMA request signalling
	assign block_mode = fifo_control_reg_q[ubdsc_pkg::FCR_DMA_MODE_BIT]
		&& fifo_control_reg_q[ubdsc_pkg::FCR_FIFO_EN_BIT];
	assign tx_free = DEPTH - tx_fifo_count;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_req_n_q <= 1'b0;
		end else if (!block_mode) begin
			tx_req_n_q <= tx_fifo_count != CNT_ZERO;
		end else if (tx_fifo_count == DEPTH) begin
			tx_req_n_q <= 1'b1;
		end else if (tx_free >= tx_trigger_spaces) begin
			tx_req_n_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_req_n_q <= 1'b1;
		end else if (!block_mode) begin
			rx_req_n_q <= rx_fifo_count == CNT_ZERO;
		end else if (rx_fifo_count == CNT_ZERO || rx_error_in_fifo) begin
			rx_req_n_q <= 1'b1;
		end else if (rx_fifo_count >= rx_trigger_level || rx_timeout_q) begin
			rx_req_n_q <= 1'b0;
		end
	end
	assign tx_dma_request_n = tx_req_n_q;
	assign rx_dma_request_n = rx_req_n_q;

	// Sleep control
	assign sleep_enable = enhanced_on
		&& interrupt_enable_reg_q[ubdsc_pkg::IER_SLEEP_BIT];
	assign sleep_ready = rx_sync_q[1] && rx_prev_q
		&& tx_fifo_count == CNT_ZERO && tx_shift_empty
		&& rx_fifo_count == CNT_ZERO && !other_int_pending;
	assign wake_event = (rx_sync_q[1] != rx_prev_q)
		|| (modem_sync2_q != modem_prev_q) || tx_fifo_write;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sleep_q <= ubdsc_pkg::SLEEP_AWAKE;
		end else begin
			unique case (sleep_q)
				ubdsc_pkg::SLEEP_AWAKE: begin
					if (sleep_enable && sleep_ready && !wake_event) begin
						sleep_q <= ubdsc_pkg::SLEEP_ASLEEP;
					end
				end
				ubdsc_pkg::SLEEP_ASLEEP: begin
					if (!sleep_enable || wake_event) begin
						sleep_q <= ubdsc_pkg::SLEEP_AWAKE;
					end
				end
				default: sleep_q <= ubdsc_pkg::SLEEP_AWAKE;
			endcase
		end
	end
	assign sleeping = (sleep_q == ubdsc_pkg::SLEEP_ASLEEP);

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	break_low_a: assert property (
		line_control_reg_q[ubdsc_pkg::LCR_BREAK_BIT] |=> !serial_out)
		else $error("break did not force line low");
	line_follow_a: assert property (
		!line_control_reg_q[ubdsc_pkg::LCR_BREAK_BIT]
		|=> serial_out == $past(tx_serial_data))
		else $error("serial output not following transmitter");
	timeout_set_a: assert property (timeout_hit |=> rx_timeout)
		else $error("timeout not flagged");
	timeout_clear_a: assert property (
		rx_timeout && rx_fifo_count == CNT_ZERO |=> !rx_timeout)
		else $error("timeout held with empty FIFO");
	single_tx_a: assert property (
		!block_mode && tx_fifo_count != CNT_ZERO |=> tx_dma_request_n)
		else $error("single transmit request stayed active");
	single_rx_a: assert property (
		!block_mode |=> rx_dma_request_n == ($past(rx_fifo_count) == CNT_ZERO))
		else $error("single receive request wrong");
	block_tx_full_a: assert property (
		block_mode && tx_fifo_count == DEPTH |=> tx_dma_request_n)
		else $error("block transmit request active when full");
	block_rx_err_a: assert property (
		block_mode && rx_error_in_fifo |=> rx_dma_request_n)
		else $error("block receive request active on error");
	block_rx_trig_a: assert property (
		block_mode && !rx_error_in_fifo && rx_fifo_count != CNT_ZERO
		&& rx_fifo_count >= rx_trigger_level |=> !rx_dma_request_n)
		else $error("block receive request missing at trigger");
	sleep_gate_a: assert property (!sleep_enable |=> !sleeping)
		else $error("asleep without sleep enable");
	sleep_clock_a: assert property (sleeping [*2] |-> !baud_tick16)
		else $error("baud tick while asleep");
	wake_write_a: assert property (sleeping && tx_fifo_write |=> !sleeping)
		else $error("no wake on transmit write");
	ier_lock_a: assert property (
		wr_sel[1] && !enhanced_on |=> interrupt_enable_reg_q[7:4]
		== $past(interrupt_enable_reg_q[7:4]))
		else $error("locked enable bits changed");

	enter_sleep_c: cover property (!sleeping ##1 sleeping);
	block_rx_c: cover property (block_mode && $fell(rx_dma_request_n));
	timeout_c: cover property ($rose(rx_timeout));
	break_c: cover property (line_control_reg_q[6] ##1 !serial_out);

endmodule : ubdsc_ctrl

// ==== src/ubdsc_pkg.sv ====
/*
 * Constants for the serial channel support block: register byte offsets,
 * field positions, reset values, write-lock masks and timing counts.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package ubdsc_pkg;

	// Register byte offsets
	localparam logic [7:0] LINE_CTRL_OFS = 8'h00;
	localparam logic [7:0] INT_ENABLE_OFS = 8'h04;
	localparam logic [7:0] FIFO_CTRL_OFS = 8'h08;
	localparam logic [7:0] MODEM_CTRL_OFS = 8'h0c;
	localparam logic [7:0] ENH_FEATURE_OFS = 8'h10;
	localparam logic [7:0] DIV_LOW_OFS = 8'h14;
	localparam logic [7:0] DIV_HIGH_OFS = 8'h18;
	localparam logic [7:0] STATUS_OFS = 8'h1c;

	// Field positions
	localparam int LCR_WLEN_LSB = 0;
	localparam int LCR_BREAK_BIT = 6;
	localparam int IER_SLEEP_BIT = 4;
	localparam int FCR_FIFO_EN_BIT = 0;
	localparam int FCR_DMA_MODE_BIT = 3;
	localparam int MCR_PRESCALE_BIT = 7;
	localparam int EFR_ENHANCED_BIT = 4;

	// Reset values
	localparam logic [7:0] LINE_CTRL_RESET = 8'h1d;
	localparam logic [7:0] INT_ENABLE_RESET = 8'h00;
	localparam logic [7:0] FIFO_CTRL_RESET = 8'h00;
	localparam logic [7:0] MODEM_CTRL_RESET = 8'h00;
	localparam logic [7:0] ENH_FEATURE_RESET = 8'h00;
	localparam logic [7:0] DIVISOR_RESET = 8'h00;

	// Fields writable only with enhanced functions on
	localparam logic [7:0] MCR_LOCK_MASK = 8'he0;
	localparam logic [7:0] FCR_LOCK_MASK = 8'h30;
	localparam logic [7:0] IER_LOCK_MASK = 8'hf0;

	// Timing counts
	localparam logic [5:0] WLEN_MIN_BITS = 6'h05;
	localparam logic [5:0] TIMEOUT_MULT = 6'h04;
	localparam logic [5:0] TIMEOUT_EXTRA_BITS = 6'h0c;
	localparam logic [3:0] TICKS_PER_BIT_M1 = 4'hf;
	localparam logic [1:0] PRESCALE4_M1 = 2'h3;
	localparam logic [1:0] STRAP_SYNC_CYCLES = 2'h2;

	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SLEEP_AWAKE = 2'b01,
		SLEEP_ASLEEP = 2'b10
	} ubdsc_sleep_type;

endpackage : ubdsc_pkg
